// ===== hw/ppc_codec.sv
// presentation packet codec: parses shared-variable, application and
// foreign packets, builds shared-variable ones; answers polls, tracks own polls
// assumes lower layers hand bytes with valid/ready, one clock
// ****************************************************
// codec
// ****************************************************
//
// Design decisions made here: the address-and-strobe port and the address map.
module ppc_codec
  import ppc_pkg::*;
#(
  parameter int unsigned NUM_VARS = 4
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic rx_valid,
  input wire ppc_rx_s rx,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  input wire logic fetch_req,
  input wire logic [1:0] fetch_index,
  input wire logic retry_exhausted,
  output logic poll_ack,
  output logic irq
);

  localparam int unsigned IW = 2;

  typedef struct packed {
    ppc_rxst_e rx_st;
    logic [7:0] rx_pos;
    logic [7:0] code;
    logic [7:0] sel_lo;
    logic [VAL_DEPTH-1:0][7:0] stage;
    logic is_resp;
    logic is_ack;
    logic tx_busy;
    logic [5:0] tx_pos;
    logic [5:0] tx_len;
    logic [7:0] tx_code;
    logic [7:0] tx_sel;
    logic [IW-1:0] tx_var;
    logic [7:0] tx_byte;
    logic poll_go;
    logic fetch_go;
    logic [IW-1:0] fetch_var;
    logic poll_pend;
    logic [13:0] poll_sel;
    logic [7:0] poll_exp;
    logic [7:0] poll_cnt;
    logic online;
    logic [NUM_EV-1:0] status;
    logic [NUM_EV-1:0] mask;
    logic [IW-1:0] v_idx;
    logic [4:0] v_byte;
    logic [7:0] last_code;
    logic [7:0] last_len;
    logic [NUM_VARS-1:0] en;
    logic [NUM_VARS-1:0] dir;
    logic [NUM_VARS-1:0][13:0] sel;
    logic [NUM_VARS-1:0][4:0] size;
    logic [NUM_VARS-1:0][VAL_DEPTH-1:0][7:0] val;
    logic [31:0] rdata;
    logic ack;
  } ppc_state_s;

  ppc_state_s st_ff;
  ppc_state_s nxt_st;
  logic hit;
  logic [IW-1:0] hit_idx;
  logic commit;
  logic poll_start;
  logic [7:0] plen;

  function automatic logic [7:0] tx_pick(input ppc_state_s s);
    logic [5:0] k;
    k = s.tx_pos - 6'h02;
    if (s.tx_pos == 6'h00)
      return s.tx_code;
    if (s.tx_pos == 6'h01)
      return s.tx_sel;
    return s.val[s.tx_var][k[4:0]];
  endfunction

  assign rx_ready = (st_ff.rx_st != S_END) && !st_ff.tx_busy;
  assign tx_valid = st_ff.tx_busy;
  assign tx_data = st_ff.tx_byte;
  assign tx_last = st_ff.tx_busy && (st_ff.tx_pos == st_ff.tx_len - 6'h01);
  assign reg_rdata = st_ff.rdata;
  assign poll_ack = st_ff.ack;
  assign irq = |(st_ff.status & st_ff.mask);

  // ****************************************************
  // next state
  // ****************************************************
  always_comb
  begin
    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] clr;
    logic [13:0] rsel;
    logic [3:0] ci;
    logic cfg_hit;
    logic [7:0] k;
    ev = '0;
    clr = '0;
    nxt_st = st_ff;
    hit = 1'h0;
    hit_idx = '0;
    commit = 1'h0;
    poll_start = 1'h0;
    rsel = {st_ff.code[5:0], st_ff.sel_lo};
    ci = reg_addr[5:2];
    cfg_hit = (reg_addr[7:6] == ADR_VCFG_HI) && (ci < 4'(NUM_VARS));
    plen = st_ff.rx_pos - 8'h02;
    k = st_ff.rx_pos - 8'h02;
    nxt_st.ack = 1'h0;
    nxt_st.rdata = '0;
    // selector lookup over enabled variables
    for (int i = 0; i < NUM_VARS; i++)
    begin
      if (!hit && st_ff.en[i] && st_ff.sel[i] == rsel)
      begin
        hit = 1'h1;
        hit_idx = IW'(i);
      end
    end
    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        ADR_CTRL: nxt_st.online = reg_wdata[0];
        ADR_STAT: clr = reg_wdata[NUM_EV-1:0];
        ADR_MASK: nxt_st.mask = reg_wdata[NUM_EV-1:0];
        ADR_POLL:
        begin
          nxt_st.poll_sel = reg_wdata[13:0];
          nxt_st.poll_exp = reg_wdata[23:16];
          nxt_st.poll_go = 1'h1;
        end
        ADR_VSEL:
        begin
          nxt_st.v_byte = reg_wdata[4:0];
          nxt_st.v_idx = reg_wdata[8+IW-1:8];
        end
        ADR_VDAT: nxt_st.val[st_ff.v_idx][st_ff.v_byte] = reg_wdata[7:0];
        default:
        begin
          if (cfg_hit)
          begin
            nxt_st.sel[ci[IW-1:0]] = reg_wdata[13:0];
            nxt_st.dir[ci[IW-1:0]] = reg_wdata[14];
            nxt_st.size[ci[IW-1:0]] = reg_wdata[20:16];
            nxt_st.en[ci[IW-1:0]] = reg_wdata[31];
          end
        end
      endcase
    end
    // register reads, answered next cycle
    if (reg_rd)
    begin
      case (reg_addr)
        ADR_CTRL:
          nxt_st.rdata = {29'h0, st_ff.poll_go, st_ff.poll_pend,
                          st_ff.online};
        ADR_STAT: nxt_st.rdata = 32'(st_ff.status);
        ADR_MASK: nxt_st.rdata = 32'(st_ff.mask);
        ADR_POLL:
          nxt_st.rdata = {st_ff.poll_cnt, st_ff.poll_exp, 2'h0,
                          st_ff.poll_sel};
        ADR_VSEL:
          nxt_st.rdata = {16'h0, 8'(st_ff.v_idx), 3'h0, st_ff.v_byte};
        ADR_VDAT:
          nxt_st.rdata = 32'(st_ff.val[st_ff.v_idx][st_ff.v_byte]);
        ADR_RXINFO:
          nxt_st.rdata = {16'h0, st_ff.last_len, st_ff.last_code};
        default:
        begin
          if (cfg_hit)
            nxt_st.rdata = {st_ff.en[ci[IW-1:0]], 10'h0,
                            st_ff.size[ci[IW-1:0]], 1'h0,
                            st_ff.dir[ci[IW-1:0]], st_ff.sel[ci[IW-1:0]]};
        end
      endcase
    end
    if (fetch_req && st_ff.en[fetch_index])
    begin
      nxt_st.fetch_go = 1'h1;
      nxt_st.fetch_var = fetch_index;
    end
    // receive side
    unique case (st_ff.rx_st)
      S_IDLE:
      begin
        if (rx_valid && rx_ready)
        begin
          nxt_st.code = rx.data;
          nxt_st.rx_pos = 8'h01;
          nxt_st.is_resp = rx.resp;
          nxt_st.is_ack = rx.acked && rx.group;
          if (rx.data[7])
            nxt_st.rx_st = rx.last ? S_END : S_NV;
          else if (rx.data[7:6] == 2'h0 || rx.data[7:4] == FRN_NIB)
            nxt_st.rx_st = rx.last ? S_END : S_MSG;
          else
          begin
            ev[EV_UNH] = 1'h1;
            nxt_st.rx_st = rx.last ? S_IDLE : S_DROP;
          end
        end
      end
      S_NV, S_MSG:
      begin
        if (rx_valid && rx_ready)
        begin
          if (st_ff.rx_st == S_NV && st_ff.rx_pos == 8'h01)
            nxt_st.sel_lo = rx.data;
          else if (st_ff.rx_st == S_NV && k < 8'(VAL_DEPTH))
            nxt_st.stage[k[4:0]] = rx.data;
          if (st_ff.rx_pos != 8'hff)
            nxt_st.rx_pos = st_ff.rx_pos + 8'h01;
          if (rx.last)
            nxt_st.rx_st = S_END;
        end
      end
      S_DROP:
      begin
        if (rx_valid && rx_ready && rx.last)
          nxt_st.rx_st = S_IDLE;
      end
      S_END:
      begin
        nxt_st.rx_st = S_IDLE;
        if (!st_ff.code[7])
        begin
          if (st_ff.rx_pos - 8'h01 <= 8'(MAX_MSG))
          begin
            nxt_st.last_code = st_ff.code;
            nxt_st.last_len = st_ff.rx_pos - 8'h01;
            ev[EV_APP] = !st_ff.code[6];
            ev[EV_FRN] = st_ff.code[6];
          end
          else
            ev[EV_UNH] = 1'h1;
        end
        else if (st_ff.rx_pos < 8'h02)
          ev[EV_UNH] = 1'h1;
        else if (st_ff.code[DIR_BIT])
        begin
          if (plen == 8'h00 && !st_ff.is_resp)
          begin
            nxt_st.ack = st_ff.is_ack;
            nxt_st.tx_busy = 1'h1;
            nxt_st.tx_pos = 6'h00;
            nxt_st.tx_code = {st_ff.code[7], 1'h0, st_ff.code[5:0]};
            nxt_st.tx_sel = st_ff.sel_lo;
            nxt_st.tx_var = hit_idx;
            if (hit && st_ff.online)
              nxt_st.tx_len = 6'h02 + 6'(st_ff.size[hit_idx]);
            else
              nxt_st.tx_len = 6'h02;
          end
          else
            ev[EV_UNH] = 1'h1;
        end
        else if (st_ff.is_resp)
        begin
          if (st_ff.poll_pend && rsel == st_ff.poll_sel)
          begin
            nxt_st.poll_cnt = st_ff.poll_cnt + 8'h01;
            ev[EV_UPD] = (plen != 8'h00);
            commit = hit && !st_ff.dir[hit_idx] &&
                     plen == 8'(st_ff.size[hit_idx]);
          end
        end
        else if (plen == 8'h00 || plen > 8'(MAX_VAL))
          ev[EV_UNH] = 1'h1;
        else if (hit && st_ff.dir[hit_idx])
          ev[EV_REJ] = 1'h1;
        else if (hit)
        begin
          commit = 1'h1;
          ev[EV_UPD] = 1'h1;
        end
        if (commit)
          nxt_st.val[hit_idx] = st_ff.stage;
      end
      default: nxt_st.rx_st = S_IDLE;
    endcase
    // transmit side: reply first, then fetch, then own poll
    if (st_ff.tx_busy && tx_ready)
    begin
      if (tx_last)
        nxt_st.tx_busy = 1'h0;
      else
        nxt_st.tx_pos = st_ff.tx_pos + 6'h01;
    end
    else if (!st_ff.tx_busy && st_ff.rx_st != S_END &&
             nxt_st.rx_st != S_END)
    begin
      if (st_ff.fetch_go)
      begin
        nxt_st.fetch_go = 1'h0;
        nxt_st.tx_busy = 1'h1;
        nxt_st.tx_var = st_ff.fetch_var;
        nxt_st.tx_pos = 6'h02;
        nxt_st.tx_len = 6'h02 + 6'(st_ff.size[st_ff.fetch_var]);
      end
      else if (st_ff.poll_go)
      begin
        poll_start = 1'h1;
        nxt_st.poll_go = 1'h0;
        nxt_st.tx_busy = 1'h1;
        nxt_st.tx_pos = 6'h00;
        nxt_st.tx_len = 6'h02;
        nxt_st.tx_code = {2'h3, st_ff.poll_sel[13:8]};
        nxt_st.tx_sel = st_ff.poll_sel[7:0];
        nxt_st.poll_pend = 1'h1;
        nxt_st.poll_cnt = 8'h00;
      end
    end
    if (st_ff.poll_pend && !poll_start)
    begin
      if (st_ff.poll_cnt == st_ff.poll_exp)
      begin
        ev[EV_ALL] = 1'h1;
        nxt_st.poll_pend = 1'h0;
      end
      else if (retry_exhausted)
      begin
        ev[EV_INC] = 1'h1;
        nxt_st.poll_pend = 1'h0;
      end
    end
    nxt_st.status = (st_ff.status & ~clr) | ev;
    nxt_st.tx_byte = tx_pick(nxt_st);
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= '0;
      st_ff.rx_st <= S_IDLE;
      st_ff.online <= ONLINE_RST;
      st_ff.mask <= MASK_RST;
    end
    else
      st_ff <= nxt_st;
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_req_done;
    st_ff.rx_st == S_END && st_ff.code[7:6] == 2'h3 &&
    st_ff.rx_pos == 8'h02 && !st_ff.is_resp;
  endsequence

  property p_rsp_code;
    s_req_done |=> tx_valid && tx_data[7:6] == 2'h2 &&
      tx_data[5:0] == $past(st_ff.code[5:0]);
  endproperty
  a_rsp_code: assert property (p_rsp_code)
    else $error("reply code byte wrong");

  property p_rsp_sel;
    s_req_done ##1 tx_ready |=> tx_data == $past(st_ff.sel_lo, 2);
  endproperty
  a_rsp_sel: assert property (p_rsp_sel)
    else $error("reply selector byte wrong");

  property p_poll_code;
    poll_start |=> tx_valid &&
      tx_data == {2'h3, $past(st_ff.poll_sel[13:8])};
  endproperty
  a_poll_code: assert property (p_poll_code)
    else $error("poll code byte wrong");

  property p_poll_len;
    poll_start ##1 tx_ready |=> tx_last;
  endproperty
  a_poll_len: assert property (p_poll_len)
    else $error("poll request not two bytes");

  property p_commit_in;
    commit |-> !st_ff.dir[hit_idx] ##1
      st_ff.val[$past(hit_idx)] == $past(st_ff.stage);
  endproperty
  a_commit_in: assert property (p_commit_in)
    else $error("bad value commit");

  property p_ack;
    s_req_done and st_ff.is_ack |=> poll_ack ##1 !poll_ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("group poll not acknowledged");

  property p_all;
    st_ff.poll_pend && !poll_start && st_ff.poll_cnt == st_ff.poll_exp
      |=> st_ff.status[EV_ALL] && !st_ff.poll_pend;
  endproperty
  a_all: assert property (p_all)
    else $error("all-answered event missing");

  property p_inc;
    st_ff.poll_pend && !poll_start && retry_exhausted &&
      st_ff.poll_cnt != st_ff.poll_exp |=> st_ff.status[EV_INC];
  endproperty
  a_inc: assert property (p_inc)
    else $error("incomplete event missing");

  property p_unh;
    st_ff.rx_st == S_IDLE && rx_valid && rx_ready &&
      rx.data[7:6] == 2'h1 && rx.data[5:4] != 2'h0
      |=> st_ff.status[EV_UNH];
  endproperty
  a_unh: assert property (p_unh)
    else $error("unhandled code not flagged");

endmodule

// ===== pkg/ppc_pkg.sv
// constants and carrier types of the presentation packet codec
// assumes one 100 MHz clock and the plain register port
package ppc_pkg;

  // ****************************************************
  // packet layout
  // ****************************************************
  localparam int unsigned MAX_VAL = 31;
  localparam int unsigned VAL_DEPTH = 32;
  localparam int unsigned MAX_MSG = 249;
  localparam logic [3:0] FRN_NIB = 4'h4;
  localparam int unsigned DIR_BIT = 6;

  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_MASK = 8'h08;
  localparam logic [7:0] ADR_POLL = 8'h0c;
  localparam logic [7:0] ADR_VSEL = 8'h10;
  localparam logic [7:0] ADR_VDAT = 8'h14;
  localparam logic [7:0] ADR_RXINFO = 8'h18;
  localparam logic [1:0] ADR_VCFG_HI = 2'h1;

  // ****************************************************
  // event bits and reset values
  // ****************************************************
  localparam int unsigned EV_UPD = 0;
  localparam int unsigned EV_ALL = 1;
  localparam int unsigned EV_INC = 2;
  localparam int unsigned EV_APP = 3;
  localparam int unsigned EV_FRN = 4;
  localparam int unsigned EV_UNH = 5;
  localparam int unsigned EV_REJ = 6;
  localparam int unsigned NUM_EV = 7;
  localparam logic ONLINE_RST = 1'h1;
  localparam logic [NUM_EV-1:0] MASK_RST = 7'h00;

  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_NV = 5'h02,
    S_MSG = 5'h04,
    S_DROP = 5'h08,
    S_END = 5'h10
  } ppc_rxst_e;

  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic group;
    logic acked;
    logic resp;
  } ppc_rx_s;

endpackage

// ===== tb/ppc_link_model.sv
// far side of the codec: lower layers feeding and draining packets
// assumes the testbench calls send at a rising edge and sets stall
module ppc_link_model
  import ppc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic stall,
  output logic rx_valid,
  output ppc_rx_s rx,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] txq[$];

  // ****************************************************
  // byte source and sink
  // ****************************************************
  initial
  begin
    rx_valid = 1'b0;
    rx = '0;
    tx_ready = 1'b0;
  end

  // code byte first, then bytes in the order given
  task automatic send(input int n, input logic [63:0] b,
                      input logic [2:0] f);
    for (int k = 0; k < n; k++)
    begin
      rx_valid <= 1'b1;
      rx <= {b[63-8*k -: 8], k == n - 1, f};
      do @(negedge clk_sys); while (!rx_ready);
      @(posedge clk_sys);
    end
    rx_valid <= 1'b0;
    rx <= {~rx.data, 4'h0};
    @(posedge clk_sys);
  endtask

  // stall answers on every other cycle
  always @(posedge clk_sys)
    tx_ready <= stall ? ~tx_ready : 1'b1;

  always @(posedge clk_sys)
    if (tx_valid && tx_ready)
      txq.push_back({tx_last, tx_data});
endmodule

// ===== tb/test_presentation_packet_codec.sv
// self-checking bench of the codec through registers and the link
// assumes the link model above on the packet side
module test_presentation_packet_codec
  import ppc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic rx_valid;
  ppc_rx_s rx;
  logic rx_ready;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_last;
  logic tx_ready;
  logic fetch_req = 1'b0;
  logic [1:0] fetch_index = 2'h0;
  logic retry_exhausted = 1'b0;
  logic poll_ack;
  logic irq;
  logic stall = 1'b0;
  int failures = 0;
  int comparisons = 0;
  int acks = 0;
  int cycles = 0;

  // ****************************************************
  // instances
  // ****************************************************
  ppc_codec #(.NUM_VARS(4)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
    .rx(rx), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .fetch_req(fetch_req), .fetch_index(fetch_index),
    .retry_exhausted(retry_exhausted), .poll_ack(poll_ack), .irq(irq));

  ppc_link_model p (.clk_sys(clk_sys), .stall(stall),
    .rx_valid(rx_valid), .rx(rx), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready));

  // ****************************************************
  // tasks
  // ****************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      failures++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    check(reg_rdata, exp);
    @(posedge clk_sys);
  endtask

  // wait for n sent bytes, last flag only on the final one
  task automatic txchk(input int n, input logic [63:0] b);
    for (int i = 0; i < 200 && p.txq.size() < n; i++)
      @(posedge clk_sys);
    repeat (6) @(posedge clk_sys);
    check(p.txq.size(), n);
    for (int k = 0; k < n && k < p.txq.size(); k++)
      check({23'h0, p.txq[k]}, {23'h0, k == n - 1, b[63-8*k -: 8]});
    p.txq.delete();
  endtask

  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************************
  // clock, reset, watchdog
  // ****************************************************
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles++;
    if (poll_ack)
      acks++;
    if (cycles == 8000)
    begin
      failures++;
      complete_run();
    end
  end

  // ****************************************************
  // scenarios
  // ****************************************************
  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rchk(ADR_CTRL, 32'h1);
    rchk(ADR_STAT, 32'h0);
    rchk(ADR_MASK, 32'h0);
    rchk(8'h30, 32'h0);
    wr(8'h40, 32'h8002_0123);
    wr(8'h44, 32'h8001_4456);
    p.send(4, 64'h8123_abcd_0000_0000, 3'h0);
    wr(ADR_VSEL, 32'h0);
    rchk(ADR_VDAT, 32'hab);
    wr(ADR_VSEL, 32'h1);
    rchk(ADR_VDAT, 32'hcd);
    wr(ADR_STAT, 32'h7f);
    p.send(3, 64'h8456_7700_0000_0000, 3'h0);
    rchk(ADR_STAT, 32'h40);
    wr(ADR_VSEL, 32'h100);
    rchk(ADR_VDAT, 32'h0);
    stall <= 1'b1;
    p.send(2, 64'hc123_0000_0000_0000, 3'h0);
    txchk(4, 64'h8123_abcd_0000_0000);
    stall <= 1'b0;
    p.send(2, 64'hc299_0000_0000_0000, 3'h6);
    txchk(2, 64'h8299_0000_0000_0000);
    check(acks, 1);
    wr(ADR_CTRL, 32'h0);
    p.send(2, 64'hc123_0000_0000_0000, 3'h0);
    txchk(2, 64'h8123_0000_0000_0000);
    wr(ADR_CTRL, 32'h1);
    wr(ADR_STAT, 32'h7f);
    p.send(2, 64'h8123_0000_0000_0000, 3'h0);
    rchk(ADR_STAT, 32'h20);
    wr(ADR_STAT, 32'h7f);
    p.send(4, 64'h1501_0203_0000_0000, 3'h0);
    rchk(ADR_STAT, 32'h08);
    rchk(ADR_RXINFO, 32'h0315);
    p.send(2, 64'h47aa_0000_0000_0000, 3'h0);
    rchk(ADR_STAT, 32'h18);
    rchk(ADR_RXINFO, 32'h0147);
    p.send(2, 64'h55aa_0000_0000_0000, 3'h0);
    rchk(ADR_STAT, 32'h38);
    wr(ADR_MASK, 32'h08);
    @(negedge clk_sys);
    check({31'h0, irq}, 32'h1);
    @(posedge clk_sys);
    wr(ADR_STAT, 32'h08);
    @(negedge clk_sys);
    check({31'h0, irq}, 32'h0);
    @(posedge clk_sys);
    wr(ADR_STAT, 32'h7f);
    wr(ADR_POLL, 32'h0002_0123);
    txchk(2, 64'hc123_0000_0000_0000);
    p.send(4, 64'h8123_1122_0000_0000, 3'h1);
    p.send(2, 64'h8123_0000_0000_0000, 3'h1);
    @(posedge clk_sys);
    rchk(ADR_STAT, 32'h03);
    rchk(ADR_POLL, 32'h0202_0123);
    wr(ADR_VSEL, 32'h0);
    rchk(ADR_VDAT, 32'h11);
    wr(ADR_STAT, 32'h7f);
    wr(ADR_POLL, 32'h0001_0123);
    txchk(2, 64'hc123_0000_0000_0000);
    retry_exhausted <= 1'b1;
    @(posedge clk_sys);
    retry_exhausted <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rchk(ADR_STAT, 32'h04);
    fetch_index <= 2'h0;
    fetch_req <= 1'b1;
    @(posedge clk_sys);
    fetch_req <= 1'b0;
    txchk(2, 64'h1122_0000_0000_0000);
    complete_run();
  end
endmodule
